// ---- hdl/scpb_channel.v ----
// Notes on behaviour
// - Separate buffer pairs for transmit and receive.
// - Each direction holds 128 Kbytes of storage.
// - Controller reads both pairs as plain memory; it writes only the transmit pair.
// - Controller fills one transmit half, serialiser drains other.
// - Receiver fills one half, controller drains other.
// - Received bytes kept until controller has read them.
// - Optional interrupt while receive buffers hold any data, outside message mode.
// - Optional interrupt when received count reaches preset.
// - Optional interrupt when a receive buffer becomes full.
// - Message mode: interrupt on completed message reception.
`include "scpb_map.vh"

module scpb_channel (
   input wire mclk_in, // System clock, 125 MHz.
   input wire rstn_in, // Synchronous reset, active low.
   input wire ctl_sel_in, // Controller memory access strobe.
   input wire ctl_wr_in, // High for a write, low for a read.
   input wire [`SCPB_CTL_AW-1:0] ctl_addr_in, // Byte address.
   input wire [7:0] ctl_wdata_in, // Write data byte.
   output reg [7:0] ctl_rdata_out, // Read data byte.
   output reg ctl_rvalid_out, // Read data valid pulse.
   input wire ctl_tx_release_in, // Controller hands over its tx half.
   input wire [`SCPB_CNT_W-1:0] ctl_tx_len_in, // Bytes loaded in it.
   output reg ctl_tx_bank_out, // Transmit half the controller fills.
   output reg ctl_tx_free_out, // That half may be loaded.
   input wire ctl_rx_release_in, // Controller has drained its rx half.
   input wire ctl_rx_flush_in, // Ask for a partly filled rx half.
   output reg ctl_rx_bank_out, // Receive half the controller drains.
   output reg ctl_rx_avail_out, // That half holds data to read.
   output reg [`SCPB_CNT_W-1:0] ctl_rx_len_out, // Bytes in that half.
   input wire msg_mode_in, // Word-serial message mode selected.
   input wire irq_data_en_in, // Enable data-present interrupt.
   input wire irq_preset_en_in, // Enable preset count interrupt.
   input wire irq_full_en_in, // Enable buffer full interrupt.
   input wire [`SCPB_TOT_W-1:0] preset_count_in, // Preset byte count.
   input wire [2:0] irq_clear_in, // Clear sticky events, one per bit.
   output reg [2:0] irq_events_out, // Sticky event flags.
   output reg irq_out, // Interrupt request level, active high.
   output reg [7:0] ser_tx_data_out, // Byte to the serialiser.
   output reg ser_tx_valid_out, // Byte offered.
   input wire ser_tx_ready_in, // Serialiser takes the byte.
   input wire [7:0] ser_rx_data_in, // Byte from the receiver.
   input wire ser_rx_valid_in, // Received byte offered.
   input wire ser_rx_eom_in, // Byte ends a message.
   output reg ser_rx_ready_out // Receiver may hand a byte over.
);

   // Two transmit halves and two receive halves of 64 Kbytes each.
   reg [7:0] tx_mem [0:(1 << `SCPB_PAIR_AW)-1];
   reg [7:0] rx_mem [0:(1 << `SCPB_PAIR_AW)-1];

   // Transmit side state.
   reg [1:0] tx_loaded_r; // Half holds bytes waiting to go out.
   reg [`SCPB_CNT_W-1:0] tx_len0_r; // Byte count of half 0.
   reg [`SCPB_CNT_W-1:0] tx_len1_r; // Byte count of half 1.
   reg tx_sbank_r; // Half being serialised.
   reg [`SCPB_CNT_W-1:0] tx_idx_r; // Next byte to fetch.
   reg [1:0] tx_st_r; // Fetch state.

   // Receive side state.
   reg [1:0] rx_given_r; // Half handed to the controller.
   reg [`SCPB_CNT_W-1:0] rx_len0_r; // Bytes stored in half 0.
   reg [`SCPB_CNT_W-1:0] rx_len1_r; // Bytes stored in half 1.
   reg rx_rbank_r; // Half being filled by the receiver.
   reg [`SCPB_CNT_W-1:0] rx_cnt_r; // Bytes in the half being filled.
   reg rx_pend_r; // Handover wanted but other half busy.
   reg [`SCPB_TOT_W-1:0] rx_total_r; // Running received byte count.

   // Combinational next values of the receive side.
   reg [`SCPB_CNT_W-1:0] rx_cnt_nxt;
   reg rx_rbank_nxt;
   reg rx_pend_nxt;
   reg [1:0] rx_given_nxt;
   reg rx_swap;
   reg full_ev;
   reg msg_ev;
   wire rx_take;
   wire [`SCPB_TOT_W-1:0] rx_total_nxt;
   wire preset_ev;

   // Picks the stored length of one of two halves.
   function [`SCPB_CNT_W-1:0] scpb_pick;
      input sel;
      input [`SCPB_CNT_W-1:0] a;
      input [`SCPB_CNT_W-1:0] b;
      begin
         scpb_pick = sel ? b : a;
      end
   endfunction

   // A byte is accepted only while the filling half has room.
   assign rx_take = ser_rx_valid_in & ser_rx_ready_out;
   assign rx_total_nxt = rx_take ? rx_total_r + 1'b1 : rx_total_r;
   // The preset event fires on the byte that makes the count match.
   assign preset_ev = rx_take & (rx_total_nxt == preset_count_in);

   // Controller memory port: transmit pair below, receive pair above.
   always @(posedge mclk_in) begin
      if (ctl_sel_in & ctl_wr_in & ~ctl_addr_in[`SCPB_RX_SEL_BIT]) begin
         tx_mem[ctl_addr_in[`SCPB_PAIR_AW-1:0]] <= ctl_wdata_in;
      end
      if (ctl_sel_in & ~ctl_wr_in) begin
         // Reads of either pair return the stored byte.
         if (ctl_addr_in[`SCPB_RX_SEL_BIT]) begin
            ctl_rdata_out <= rx_mem[ctl_addr_in[`SCPB_PAIR_AW-1:0]];
         end else begin
            ctl_rdata_out <= tx_mem[ctl_addr_in[`SCPB_PAIR_AW-1:0]];
         end
      end
   end

   // Read valid marks the cycle after a read strobe.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctl_rvalid_out <= 1'b0;
      end else begin
         ctl_rvalid_out <= ctl_sel_in & ~ctl_wr_in;
      end
   end

   // Controller side of the transmit pair: it loads one half and hands it
   // over, then moves to the other half once that one is released.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctl_tx_bank_out <= 1'b0;
         tx_len0_r <= {`SCPB_CNT_W{1'b0}};
         tx_len1_r <= {`SCPB_CNT_W{1'b0}};
      end else if (ctl_tx_release_in & ctl_tx_free_out) begin
         // A handover of a half still in use is ignored.
         if (ctl_tx_bank_out) begin
            tx_len1_r <= ctl_tx_len_in;
         end else begin
            tx_len0_r <= ctl_tx_len_in;
         end
         ctl_tx_bank_out <= ~ctl_tx_bank_out;
      end
   end

   // Loaded flags: set by controller handover, cleared when drained.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         tx_loaded_r <= 2'h0;
         ctl_tx_free_out <= 1'b1;
      end else begin
         if (tx_st_r == `SCPB_TX_IDLE && tx_loaded_r[tx_sbank_r] &&
             tx_idx_r == scpb_pick(tx_sbank_r, tx_len0_r, tx_len1_r)) begin
            tx_loaded_r[tx_sbank_r] <= 1'b0;
         end
         if (ctl_tx_release_in & ctl_tx_free_out) begin
            tx_loaded_r[ctl_tx_bank_out] <= 1'b1;
         end
         // The controller's next half is free when not still loaded.
         if (ctl_tx_release_in & ctl_tx_free_out) begin
            ctl_tx_free_out <= ~tx_loaded_r[~ctl_tx_bank_out];
         end else begin
            ctl_tx_free_out <= ~tx_loaded_r[ctl_tx_bank_out];
         end
      end
   end

   // Serialiser side: fetch bytes of the loaded half in order, hold each
   // until taken, and move to the other half as soon as this one is
   // exhausted, then wait there until the other has been handed over.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         tx_st_r <= `SCPB_TX_IDLE;
         tx_sbank_r <= 1'b0;
         tx_idx_r <= {`SCPB_CNT_W{1'b0}};
         ser_tx_valid_out <= 1'b0;
         ser_tx_data_out <= 8'h00;
      end else begin
         case (tx_st_r)
            `SCPB_TX_IDLE: begin
               if (tx_loaded_r[tx_sbank_r]) begin
                  if (tx_idx_r ==
                      scpb_pick(tx_sbank_r, tx_len0_r, tx_len1_r)) begin
                     // Half exhausted: give it back, use the other.
                     tx_sbank_r <= ~tx_sbank_r;
                     tx_idx_r <= {`SCPB_CNT_W{1'b0}};
                  end else begin
                     tx_st_r <= `SCPB_TX_FETCH;
                  end
               end
            end
            `SCPB_TX_FETCH: begin
               // Synchronous memory read of the next byte.
               ser_tx_data_out <=
                  tx_mem[{tx_sbank_r, tx_idx_r[`SCPB_BANK_AW-1:0]}];
               ser_tx_valid_out <= 1'b1;
               tx_idx_r <= tx_idx_r + 1'b1;
               tx_st_r <= `SCPB_TX_HOLD;
            end
            `SCPB_TX_HOLD: begin
               // Byte stands until the serialiser takes it.
               if (ser_tx_ready_in) begin
                  ser_tx_valid_out <= 1'b0;
                  tx_st_r <= `SCPB_TX_IDLE;
               end
            end
            default: begin
               tx_st_r <= `SCPB_TX_IDLE;
               ser_tx_valid_out <= 1'b0;
            end
         endcase
      end
   end

   // Receive side next state: count bytes into the filling half and hand
   // it over when full, at message end, or on a flush request, but only
   // once the controller has released the other half.
   always @* begin
      rx_cnt_nxt = rx_cnt_r;
      rx_rbank_nxt = rx_rbank_r;
      rx_pend_nxt = rx_pend_r;
      rx_given_nxt = rx_given_r;
      rx_swap = 1'b0;
      full_ev = 1'b0;
      msg_ev = 1'b0;
      if (ctl_rx_release_in & ctl_rx_avail_out) begin
         rx_given_nxt[ctl_rx_bank_out] = 1'b0;
      end
      if (rx_take) begin
         rx_cnt_nxt = rx_cnt_r + 1'b1;
         if (rx_cnt_nxt == `SCPB_BANK_BYTES) begin
            full_ev = 1'b1;
            rx_pend_nxt = 1'b1;
         end
         if (msg_mode_in & ser_rx_eom_in) begin
            msg_ev = 1'b1;
            rx_pend_nxt = 1'b1;
         end
      end
      if (ctl_rx_flush_in && rx_cnt_nxt != {`SCPB_CNT_W{1'b0}}) begin
         rx_pend_nxt = 1'b1;
      end
      // Swap only into a half the controller has released.
      if (rx_pend_nxt & ~rx_given_nxt[~rx_rbank_r]) begin
         rx_swap = 1'b1;
         rx_given_nxt[rx_rbank_r] = 1'b1;
         rx_rbank_nxt = ~rx_rbank_r;
         rx_cnt_nxt = {`SCPB_CNT_W{1'b0}};
         rx_pend_nxt = 1'b0;
      end
   end

   // Stores received bytes; the half handed to the controller is never overwritten.
   always @(posedge mclk_in) begin
      if (rx_take) begin
         rx_mem[{rx_rbank_r, rx_cnt_r[`SCPB_BANK_AW-1:0]}] <=
            ser_rx_data_in;
      end
   end

   // Receive side registers and the controller view of them.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         rx_given_r <= 2'h0;
         rx_len0_r <= {`SCPB_CNT_W{1'b0}};
         rx_len1_r <= {`SCPB_CNT_W{1'b0}};
         rx_rbank_r <= 1'b0;
         rx_cnt_r <= {`SCPB_CNT_W{1'b0}};
         rx_pend_r <= 1'b0;
         rx_total_r <= {`SCPB_TOT_W{1'b0}};
         ser_rx_ready_out <= 1'b0;
         ctl_rx_bank_out <= 1'b0;
      end else begin
         rx_given_r <= rx_given_nxt;
         rx_rbank_r <= rx_rbank_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_pend_r <= rx_pend_nxt;
         rx_total_r <= rx_total_nxt;
         if (rx_swap & ~rx_rbank_r) begin
            rx_len0_r <= rx_cnt_r + {{(`SCPB_CNT_W-1){1'b0}}, rx_take};
         end
         if (rx_swap & rx_rbank_r) begin
            rx_len1_r <= rx_cnt_r + {{(`SCPB_CNT_W-1){1'b0}}, rx_take};
         end
         // Stall the receiver while the filling half is full.
         ser_rx_ready_out <= (rx_cnt_nxt != `SCPB_BANK_BYTES);
         // The controller moves to the other half after releasing one.
         if (ctl_rx_release_in & ctl_rx_avail_out) begin
            ctl_rx_bank_out <= ~ctl_rx_bank_out;
         end
      end
   end

   // Registered summary of the half the controller should drain.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctl_rx_avail_out <= 1'b0;
         ctl_rx_len_out <= {`SCPB_CNT_W{1'b0}};
      end else begin
         ctl_rx_avail_out <= rx_given_r[ctl_rx_bank_out] &
            ~(ctl_rx_release_in & ctl_rx_avail_out);
         ctl_rx_len_out <= scpb_pick(ctl_rx_bank_out, rx_len0_r, rx_len1_r);
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         irq_events_out <= `SCPB_EV_RST;
      end else begin
         irq_events_out[`SCPB_EV_PRESET] <= preset_ev |
            (irq_events_out[`SCPB_EV_PRESET] &
             ~irq_clear_in[`SCPB_EV_PRESET]);
         irq_events_out[`SCPB_EV_FULL] <= full_ev |
            (irq_events_out[`SCPB_EV_FULL] &
             ~irq_clear_in[`SCPB_EV_FULL]);
         irq_events_out[`SCPB_EV_MSG] <= msg_ev |
            (irq_events_out[`SCPB_EV_MSG] &
             ~irq_clear_in[`SCPB_EV_MSG]);
      end
   end

   // Interrupt level: data present, or any enabled sticky event.
   always @(posedge mclk_in) begin
      if (!rstn_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= (irq_data_en_in & ~msg_mode_in &
                     ((|rx_given_r) | (rx_cnt_r != 17'h00000))) |
            (irq_preset_en_in & irq_events_out[`SCPB_EV_PRESET]) |
            (irq_full_en_in & irq_events_out[`SCPB_EV_FULL]) |
            (msg_mode_in & irq_events_out[`SCPB_EV_MSG]);
      end
   end

endmodule // scpb_channel

// ---- hdl/scpb_map.vh ----
`ifndef SCPB_MAP_VH
`define SCPB_MAP_VH

// Byte address width of one half of a buffer pair.
`define SCPB_BANK_AW 16
// Bytes in one half of a buffer pair (64 Kbytes, two halves make 128 Kbytes).
`define SCPB_BANK_BYTES 17'h10000
// Byte address width of one whole buffer pair (128 Kbytes).
`define SCPB_PAIR_AW 17
// Controller address width: transmit pair below, receive pair above.
`define SCPB_CTL_AW 18
// Controller address bit that selects the receive pair.
`define SCPB_RX_SEL_BIT 17
// Width of byte counters, wide enough to hold a full half.
`define SCPB_CNT_W 17
// Width of the running receive byte count used for the preset event.
`define SCPB_TOT_W 24
// Positions of the sticky event flags and their clear bits.
`define SCPB_EV_PRESET 0
`define SCPB_EV_FULL 1
`define SCPB_EV_MSG 2
// Reset value of the sticky event flags.
`define SCPB_EV_RST 3'h0
// Transmit fetch states.
`define SCPB_TX_IDLE 2'h0
`define SCPB_TX_FETCH 2'h1
`define SCPB_TX_HOLD 2'h2

`endif

// ---- tb/scpb_channel_bench.sv ----
`include "scpb_map.vh"
module scpb_channel_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 0, rstn_in = 0, ctl_sel_in = 0, ctl_wr_in = 0;
   logic [17:0] ctl_addr_in = 0;
   logic [7:0] ctl_wdata_in = 0, ctl_rdata_out, ser_tx_data_out;
   logic [7:0] ser_rx_data_in;
   logic ctl_rvalid_out, ctl_tx_release_in = 0, ctl_tx_bank_out;
   logic [16:0] ctl_tx_len_in = 0, ctl_rx_len_out;
   logic ctl_tx_free_out, ctl_rx_release_in = 0, ctl_rx_flush_in = 0;
   logic ctl_rx_bank_out, ctl_rx_avail_out, msg_mode_in = 0;
   logic irq_data_en_in = 0, irq_preset_en_in = 0, irq_full_en_in = 0;
   logic [23:0] preset_count_in = 24'hffffff;
   logic [2:0] irq_clear_in = 0, irq_events_out;
   logic irq_out, ser_tx_valid_out, ser_tx_ready_in, ser_rx_valid_in;
   logic ser_rx_eom_in, ser_rx_ready_out, stall = 0;
   int n_mismatch = 0, comparisons = 0, i;
   scpb_channel u_scpb_channel (.mclk_in, .rstn_in, .ctl_sel_in, .ctl_wr_in,
      .ctl_addr_in, .ctl_wdata_in, .ctl_rdata_out, .ctl_rvalid_out,
      .ctl_tx_release_in, .ctl_tx_len_in, .ctl_tx_bank_out, .ctl_tx_free_out,
      .ctl_rx_release_in, .ctl_rx_flush_in, .ctl_rx_bank_out,
      .ctl_rx_avail_out, .ctl_rx_len_out, .msg_mode_in, .irq_data_en_in,
      .irq_preset_en_in, .irq_full_en_in, .preset_count_in, .irq_clear_in,
      .irq_events_out, .irq_out, .ser_tx_data_out, .ser_tx_valid_out,
      .ser_tx_ready_in, .ser_rx_data_in, .ser_rx_valid_in, .ser_rx_eom_in,
      .ser_rx_ready_out);
   scpb_serial_model u_scpb_serial_model (.mclk_in,
      .tx_data_in(ser_tx_data_out), .tx_valid_in(ser_tx_valid_out),
      .stall_in(stall), .tx_ready_out(ser_tx_ready_in),
      .rx_ready_in(ser_rx_ready_out), .rx_data_out(ser_rx_data_in),
      .rx_valid_out(ser_rx_valid_in), .rx_eom_out(ser_rx_eom_in));
   // Free-running 125 MHz clock.
   always #4 mclk_in = ~mclk_in;
   task automatic step;
      @(posedge mclk_in);
      #1;
   endtask
   task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t value %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({16'h0000, got}, {16'h0000, exp});
   endtask
   // One byte access; a read is answered one cycle after the strobe.
   task automatic mem(input logic [17:0] a, input logic wr,
                      input logic [7:0] d);
      ctl_sel_in = 1;
      ctl_wr_in = wr;
      ctl_addr_in = a;
      ctl_wdata_in = d;
      step;
      ctl_sel_in = 0;
      if (!wr) chk_bit(ctl_rvalid_out, 1);
      if (!wr) chk_word({9'h000, ctl_rdata_out}, {9'h000, d});
      step;
   endtask
   // Bounded wait on the receive handover level.
   task automatic wait_avail;
      repeat (300) if (!ctl_rx_avail_out) step;
   endtask
   // Pulses one control input for a single cycle.
   task automatic pulse(ref logic s);
      s = 1;
      step;
      s = 0;
   endtask
   // Transmit pair and receive pair are separate memories. The receive
   // pair only takes bytes from the receiver, so a controller write aimed
   // at it must leave the transmit byte at the same offset untouched.
   task automatic t_mem;
      mem(18'h00010, 1, 8'h5a);
      mem(18'h20010, 1, 8'hc3);
      mem(18'h1ffff, 1, 8'ha5);
      mem(18'h00010, 0, 8'h5a);
      mem(18'h1ffff, 0, 8'ha5);
   endtask
   // Two halves sent in turn with a stalling serialiser.
   task automatic t_tx;
      chk_bit(ctl_tx_free_out, 1);
      for (i = 0; i < 3; i++) mem({2'b00, 16'(i)}, 1, 8'h10 + 8'(i));
      stall = 1;
      ctl_tx_len_in = 17'h3;
      pulse(ctl_tx_release_in);
      chk_bit(ctl_tx_bank_out, 1);
      repeat (50) if (!ctl_tx_free_out) step;
      for (i = 0; i < 2; i++) mem({2'b01, 16'(i)}, 1, 8'h20 + 8'(i));
      ctl_tx_len_in = 17'h2;
      pulse(ctl_tx_release_in);
      chk_bit(ctl_tx_bank_out, 0);
      repeat (60) step;
      chk_word(17'(u_scpb_serial_model.got.size()), 17'h5);
      for (i = 0; i < 5; i++)
         chk_word({9'h0, u_scpb_serial_model.got[i]},
                  (i < 3) ? 17'h10 + 17'(i) : 17'h1d + 17'(i));
   endtask
   // Reads one handed-over receive half and gives it back.
   task automatic drain(input int n, input logic [7:0] base);
      wait_avail;
      chk_word(ctl_rx_len_out, 17'(n));
      for (i = 0; i < n; i++)
         mem({1'b1, ctl_rx_bank_out, 16'(i)}, 0, base + 8'(i));
      pulse(ctl_rx_release_in);
      chk_bit(ctl_rx_avail_out, 0);
   endtask
   // Message end hands the half over and raises the message event.
   task automatic t_msg;
      msg_mode_in = 1;
      for (i = 0; i < 3; i++) u_scpb_serial_model.send(8'h30 + 8'(i), i == 2);
      u_scpb_serial_model.idle;
      wait_avail;
      chk_bit(irq_events_out[`SCPB_EV_MSG], 1);
      chk_bit(irq_out, 1);
      drain(3, 8'h30);
      irq_clear_in = 3'h4;
      step;
      irq_clear_in = 3'h0;
      chk_bit(irq_events_out[`SCPB_EV_MSG], 0);
      msg_mode_in = 0;
   endtask
   // Fifth byte since reset meets the preset; flush shows data irq.
   task automatic t_preset;
      preset_count_in = 24'h000005;
      irq_preset_en_in = 1;
      irq_data_en_in = 1;
      for (i = 0; i < 2; i++) u_scpb_serial_model.send(8'h40 + 8'(i), 0);
      u_scpb_serial_model.idle;
      step;
      step;
      chk_bit(irq_events_out[`SCPB_EV_PRESET], 1);
      pulse(ctl_rx_flush_in);
      wait_avail;
      step;
      chk_bit(irq_out, 1);
      drain(2, 8'h40);
   endtask
   // A half filled to the last byte swaps and flags full.
   task automatic t_full;
      irq_full_en_in = 1;
      for (i = 0; i < 65536; i++) u_scpb_serial_model.send(8'(i), 0);
      u_scpb_serial_model.idle;
      wait_avail;
      chk_bit(irq_events_out[`SCPB_EV_FULL], 1);
      chk_word(ctl_rx_len_out, `SCPB_BANK_BYTES);
      mem({1'b1, ctl_rx_bank_out, 16'hffff}, 0, 8'hff);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Watchdog sized well above the longest scenario.
   initial begin
      repeat (90000) @(posedge mclk_in);
      n_mismatch++;
      tally_and_finish;
   end
   // Reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(posedge mclk_in);
      #1;
      rstn_in = 1;
      step;
      t_mem;
      t_tx;
      t_msg;
      t_preset;
      t_full;
      tally_and_finish;
   end
endmodule // scpb_channel_bench

// ---- tb/scpb_chk_sva.sv ----
// Watches the channel ports and ties handshake, handover, event and interrupt outputs to their causes.
module scpb_chk (
   input wire mclk_in, // Clock.
   input wire rstn_in, // Reset, active low.
   input wire ctl_sel_in, // Access strobe.
   input wire ctl_wr_in, // Write flag.
   input wire ctl_rvalid_out, // Read valid.
   input wire ctl_tx_release_in, // Tx handover.
   input wire ctl_tx_bank_out, // Tx half.
   input wire ctl_tx_free_out, // Tx half free.
   input wire [7:0] ser_tx_data_out, // Tx byte.
   input wire ser_tx_valid_out, // Tx offered.
   input wire ser_tx_ready_in, // Tx taken.
   input wire ctl_rx_release_in, // Rx drained.
   input wire ctl_rx_bank_out, // Rx half.
   input wire ctl_rx_avail_out, // Rx data held.
   input wire msg_mode_in, // Message mode.
   input wire ser_rx_valid_in, // Rx offered.
   input wire ser_rx_eom_in, // Rx message end.
   input wire ser_rx_ready_out, // Rx may send.
   input wire irq_data_en_in, // Data irq enable.
   input wire [2:0] irq_clear_in, // Event clears.
   input wire [2:0] irq_events_out, // Events.
   input wire irq_out // Interrupt.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);
   property p_rd;
      ctl_sel_in && !ctl_wr_in |=> ctl_rvalid_out;
   endproperty
   a_rd: assert property (p_rd) else $error("read unanswered");
   property p_rdq;
      !(ctl_sel_in && !ctl_wr_in) |=> !ctl_rvalid_out;
   endproperty
   a_rdq: assert property (p_rdq) else $error("stray read valid");
   property p_txsw;
      ctl_tx_release_in && ctl_tx_free_out |=> $changed(ctl_tx_bank_out);
   endproperty
   a_txsw: assert property (p_txsw) else $error("tx half kept");
   property p_txst;
      !(ctl_tx_release_in && ctl_tx_free_out) |=> $stable(ctl_tx_bank_out);
   endproperty
   a_txst: assert property (p_txst) else $error("tx half moved");
   property p_txh;
      ser_tx_valid_out && !ser_tx_ready_in
         |=> ser_tx_valid_out && $stable(ser_tx_data_out);
   endproperty
   a_txh: assert property (p_txh) else $error("tx byte dropped");
   property p_rxh;
      ctl_rx_avail_out && !ctl_rx_release_in |=> ctl_rx_avail_out;
   endproperty
   a_rxh: assert property (p_rxh) else $error("rx data lost");
   property p_rxsw;
      ctl_rx_avail_out && ctl_rx_release_in
         |=> !ctl_rx_avail_out && $changed(ctl_rx_bank_out);
   endproperty
   a_rxsw: assert property (p_rxsw) else $error("rx swap wrong");
   property p_msg;
      msg_mode_in && ser_rx_valid_in && ser_rx_ready_out && ser_rx_eom_in
         |-> ##[1:2] irq_events_out[2];
   endproperty
   a_msg: assert property (p_msg) else $error("no message event");
   property p_full;
      irq_events_out[1] && !irq_clear_in[1] |=> irq_events_out[1];
   endproperty
   a_full: assert property (p_full) else $error("full event lost");
   property p_dat;
      (irq_data_en_in && !msg_mode_in && ctl_rx_avail_out)[*2] |-> irq_out;
   endproperty
   a_dat: assert property (p_dat) else $error("no data irq");
endmodule // scpb_chk

bind scpb_channel scpb_chk u_scpb_chk (.mclk_in, .rstn_in, .ctl_sel_in,
   .ctl_wr_in, .ctl_rvalid_out, .ctl_tx_release_in, .ctl_tx_bank_out,
   .ctl_tx_free_out, .ser_tx_data_out, .ser_tx_valid_out, .ser_tx_ready_in,
   .ctl_rx_release_in, .ctl_rx_bank_out, .ctl_rx_avail_out, .msg_mode_in,
   .ser_rx_valid_in, .ser_rx_eom_in, .ser_rx_ready_out, .irq_data_en_in,
   .irq_clear_in, .irq_events_out, .irq_out);

// ---- tb/scpb_serial_model.sv ----
// Serial side: a byte sink that may stall and a byte source.
module scpb_serial_model (
   input wire mclk_in, // Clock.
   input wire [7:0] tx_data_in, // Byte offered.
   input wire tx_valid_in, // Offer strobe.
   input wire stall_in, // Take only every other cycle.
   output logic tx_ready_out, // Byte taken.
   input wire rx_ready_in, // Channel may take.
   output logic [7:0] rx_data_out, // Byte sent.
   output logic rx_valid_out, // Send strobe.
   output logic rx_eom_out // Last byte of a message.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got [$]; // Bytes taken so far.
   initial begin
      rx_valid_out = 1'b0;
      rx_eom_out = 1'b0;
      rx_data_out = 8'h00;
   end
   // Logs each accepted byte; slow mode halves the take rate.
   always @(posedge mclk_in) begin
      if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
      tx_ready_out <= stall_in ? ~tx_ready_out : 1'b1;
   end
   // Holds a byte until the channel takes it.
   task automatic send(input logic [7:0] d, input logic eom);
      rx_valid_out = 1'b1;
      rx_data_out = d;
      rx_eom_out = eom;
      while (!rx_ready_in) begin
         @(posedge mclk_in);
         #1;
      end
      @(posedge mclk_in);
      #1;
   endtask
   // Leaves the line with a changed value so nothing stale is read.
   task automatic idle;
      rx_valid_out = 1'b0;
      rx_eom_out = 1'b0;
      rx_data_out = ~rx_data_out;
   endtask
endmodule // scpb_serial_model
